/* File: core/core_regs_pkg.sv */
// Package with register offsets, field positions, reset values and timing constants.
package core_regs_pkg;
  // Register byte addresses on the AXI4-Lite slave.
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_OPTION = 4'h4;
  localparam logic [3:0] ADDR_EVENTS = 4'h8;
  localparam logic [3:0] ADDR_PULLUP = 4'hC;
  // Status register field positions.
  localparam int ST_CARRY = 0;
  localparam int ST_NIBBLE = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_SLEEP_N = 3;
  localparam int ST_EXPIRY_N = 4;
  localparam int ST_BANK = 5;
  localparam int ST_RSV6 = 6;
  localparam int ST_RSV7 = 7;
  // Option register field positions.
  localparam int OP_RATE_LO = 0;
  localparam int OP_OWNER = 3;
  localparam int OP_T0_EDGE = 4;
  localparam int OP_T0_SRC = 5;
  localparam int OP_IRQ_EDGE = 6;
  localparam int OP_PULLUP_DIS = 7;
  // Event flag register field positions.
  localparam int EV_EXT_IRQ = 0;
  localparam int EV_T0_TICK = 1;
  // Reset values.
  localparam logic [7:0] OPTION_RST = 8'hFF;
  localparam logic [7:0] STATUS_RST = 8'h18;
  // Instruction clock divide from the oscillator.
  localparam int INSTR_DIV = 4;
  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // ALU operation codes.
  typedef enum logic [2:0] {
    ALU_NONE = 3'h0,
    ALU_ADD = 3'h1,
    ALU_SUB = 3'h2,
    ALU_LOGIC = 3'h3,
    ALU_ROR = 3'h4,
    ALU_ROL = 3'h5
  } alu_op_t;
endpackage

/* File: core/alu_flag_unit.sv */
// Computes zero, nibble carry and carry for one ALU operation.
`timescale 1ns/1ps
module alu_flag_unit
  import core_regs_pkg::*;
(
  // Operation request.
  input wire alu_op_t op,
  input wire logic [7:0] opa,
  input wire logic [7:0] opb,
  input wire logic carry_in,
  // Result and flags.
  output logic [7:0] result,
  output logic zero,
  output logic nibble_cy,
  output logic carry,
  output logic upd_znc,
  output logic upd_z,
  output logic upd_c
);
  logic [8:0] sum;
  logic [4:0] lo;
  logic [7:0] addend;
  logic add_cin;

  // Subtraction adds the two's complement, so carries act as not-borrow.
  always_comb begin
    addend = (op == ALU_SUB) ? ~opb : opb; // see R8
    add_cin = (op == ALU_SUB);
    sum = {1'b0, opa} + {1'b0, addend} + {8'h00, add_cin};
    lo = {1'b0, opa[3:0]} + {1'b0, addend[3:0]} + {4'h0, add_cin};
    result = 8'h00;
    carry = carry_in;
    nibble_cy = 1'b0;
    upd_znc = 1'b0;
    upd_z = 1'b0;
    upd_c = 1'b0;
    unique case (op)
      ALU_ADD, ALU_SUB: begin
        result = sum[7:0];
        nibble_cy = lo[4]; // see R6
        carry = sum[8]; // see R7
        upd_znc = 1'b1;
      end
      ALU_LOGIC: begin
        result = opa & opb;
        upd_z = 1'b1;
      end
      ALU_ROR: begin
        result = {carry_in, opa[7:1]};
        carry = opa[0]; // see R9
        upd_c = 1'b1;
      end
      ALU_ROL: begin
        result = {opa[6:0], carry_in};
        carry = opa[7]; // see R9
        upd_c = 1'b1;
      end
      default: begin
        result = opa;
      end
    endcase
    zero = (result == 8'h00); // see R5
  end
endmodule

/* File: core/prescale_unit.sv */
// Shared timer/watchdog prescaler with power-of-two tap select.
`timescale 1ns/1ps
module prescale_unit
  import core_regs_pkg::*;
#(
  parameter int WIDTH = 8
)(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Control.
  input wire logic tick_in,
  input wire logic [2:0] rate,
  input wire logic to_watchdog,
  // Outputs.
  output logic timer_tick,
  output logic watchdog_tick
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } ps_state_t;
  ps_state_t st_ff;
  ps_state_t nxt_st;
  logic [WIDTH-1:0] cnt_next;
  logic [WIDTH:0] taps;

  // The counter advances once per source tick.
  always_comb begin
    nxt_st = st_ff;
    cnt_next = st_ff.cnt + {{(WIDTH-1){1'b0}}, 1'b1};
    if (tick_in) begin
      nxt_st.cnt = cnt_next;
    end
  end

  // Tap k fires when the low k bits roll over, giving divide by 2^k.
  assign taps[0] = tick_in;
  for (genvar k = 1; k <= WIDTH; k++) begin : g_tap
    assign taps[k] = tick_in && (st_ff.cnt[k-1:0] == {k{1'b1}});
  end

  // Only the selected owner sees the divided ticks; the other runs 1:1.
  // The index is one bit wider than the rate, so the top rate reaches the last tap.
  assign timer_tick = to_watchdog ? tick_in : taps[{1'b0, rate} + 4'd1]; // see R16, R17, R18
  assign watchdog_tick = to_watchdog ? taps[rate] : tick_in; // see R17

  // State register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule

/* File: core/core_status_and_option_regs.sv */
// Core status and option registers with flag logic and AXI4-Lite access.
//
// Summary of operation
// R1 - Writes to status from a flag-updating operation leave the three flags alone.
// R2 - Status bit 5 selects data bank: 1 upper half, 0 lower half.
// R3 - Expiry flag set at reset, clear-watchdog, sleep; cleared by time-out.
// R4 - Sleep flag set at reset or clear-watchdog; cleared by sleep.
// R5 - Zero flag follows whether the operation result is zero.
// R6 - Add and subtract set nibble carry from bit 3 carry-out.
// R7 - Add and subtract set carry from the top bit carry-out.
// R8 - Subtract adds two's complement; carries read as inverted borrows.
// R9 - Rotates load carry with the bit shifted out.
// R10 - Software keeps status bits 7 and 6 at zero.
// R11 - Software alters status only with bit set, clear, swap or move.
// R12 - Option bit 7 high disables all pull-ups; else per-pin latches decide.
// R13 - Option bit 6 picks rising or falling external interrupt edge.
// R14 - Option bit 5 picks external pin or instruction clock for the timer.
// R15 - Option bit 4 picks falling or rising external timer edge.
// R16 - Option bit 3 gives the prescaler to the watchdog or timer.
// R17 - Rate n divides timer by 2^(n+1), watchdog by 2^n.
// R18 - With prescaler on the watchdog, the timer counts undivided.
// R19 - Event flags set on their condition regardless of any enable.
// R20 - Software clears event flags before enabling them.
// R21 - Reset loads option all ones, bank 0, expiry and sleep flags one.
//
// The AXI4-Lite slave port and the address map were decided locally.
`timescale 1ns/1ps
module core_status_and_option_regs
  import core_regs_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address.
  input wire logic awvalid,
  output logic awready,
  input wire logic [3:0] awaddr,
  // AXI4-Lite write data.
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response.
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address.
  input wire logic arvalid,
  output logic arready,
  input wire logic [3:0] araddr,
  // AXI4-Lite read data.
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Core datapath port.
  input wire alu_op_t alu_op,
  input wire logic [7:0] alu_a,
  input wire logic [7:0] alu_b,
  input wire logic status_wr,
  input wire logic [7:0] status_wdata,
  output logic [7:0] alu_result,
  // Instruction events.
  input wire logic watchdog_clear_op,
  input wire logic sleep_op,
  input wire logic watchdog_timeout,
  input wire logic instr_tick,
  // Pins.
  input wire logic ext_irq_pin,
  input wire logic timer0_ext_clock_pin,
  input wire logic [5:0] pullup_latch,
  // Outputs to the rest of the core.
  output logic bank_select,
  output logic [5:0] pullup_en,
  output logic timer0_tick,
  output logic watchdog_tick,
  output logic ext_irq_flag,
  output logic [7:0] core_status,
  output logic [7:0] timer_option_ctrl
);
  typedef struct packed {
    // Register contents.
    logic [7:0] status;
    logic [7:0] option;
    // Sticky event flags.
    logic ext_flag;
    logic t0_flag;
    // Pin synchronisers and the edge history behind them.
    logic [1:0] irq_sync;
    logic [1:0] t0_sync;
    logic irq_prev;
    logic t0_prev;
    // Write half that arrived first, kept until its partner comes.
    logic aw_held;
    logic [3:0] aw_addr;
    logic w_held;
    logic [7:0] w_data;
    logic w_strb0;
    // Response and read return.
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } regs_state_t;
  regs_state_t st_ff;
  regs_state_t nxt_st;

  // ALU result and flags.
  logic [7:0] res;
  logic f_zero;
  logic f_nib;
  logic f_cy;
  logic upd_znc;
  logic upd_z;
  logic upd_c;
  // Pin edge detection.
  logic t0_src_tick;
  logic irq_rise;
  logic irq_fall;
  logic irq_edge_hit;
  logic t0_edge_hit;
  // Bus control.
  logic wr_go;
  logic rd_go;
  logic sw_clear_ext;
  logic sw_clear_t0;
  logic [7:0] st_w;

  // Flag computation for the current operation.
  alu_flag_unit u_alu (
    .op(alu_op),
    .opa(alu_a),
    .opb(alu_b),
    .carry_in(st_ff.status[ST_CARRY]),
    .result(res),
    .zero(f_zero),
    .nibble_cy(f_nib),
    .carry(f_cy),
    .upd_znc(upd_znc),
    .upd_z(upd_z),
    .upd_c(upd_c)
  );

  // Timer source select and edge polarity, from synchronised pin copies.
  always_comb begin
    irq_rise = st_ff.irq_sync[1] && !st_ff.irq_prev;
    irq_fall = !st_ff.irq_sync[1] && st_ff.irq_prev;
    irq_edge_hit = st_ff.option[OP_IRQ_EDGE] ? irq_rise : irq_fall; // see R13
    // The timer pin counts on the edge that the option selects.
    if (st_ff.option[OP_T0_EDGE]) begin
      t0_edge_hit = !st_ff.t0_sync[1] && st_ff.t0_prev; // see R15
    end else begin
      t0_edge_hit = st_ff.t0_sync[1] && !st_ff.t0_prev; // see R15
    end
    t0_src_tick = st_ff.option[OP_T0_SRC] ? t0_edge_hit : instr_tick; // see R14
  end

  // Shared prescaler between timer and watchdog.
  prescale_unit #(.WIDTH(8)) u_ps (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick_in(t0_src_tick),
    .rate(st_ff.option[OP_RATE_LO +: 3]),
    .to_watchdog(st_ff.option[OP_OWNER]),
    .timer_tick(timer0_tick),
    .watchdog_tick(watchdog_tick)
  );

  // Bus handshakes: address and data are taken in either order.
  assign awready = !st_ff.aw_held && !st_ff.bvalid;
  assign wready = !st_ff.w_held && !st_ff.bvalid;
  assign arready = !st_ff.rvalid;
  assign wr_go = (st_ff.aw_held || (awvalid && awready))
    && (st_ff.w_held || (wvalid && wready)) && !st_ff.bvalid;
  assign rd_go = arvalid && arready;

  // Next-state logic for registers, flags and bus.
  always_comb begin
    logic [3:0] waddr;
    logic [7:0] wbyte;
    logic wlane;
    waddr = st_ff.aw_held ? st_ff.aw_addr : awaddr;
    wbyte = st_ff.w_held ? st_ff.w_data : wdata[7:0];
    wlane = st_ff.w_held ? st_ff.w_strb0 : wstrb[0];
    nxt_st = st_ff;
    st_w = st_ff.status;
    sw_clear_ext = 1'b0;
    sw_clear_t0 = 1'b0;

    // Pin synchronisers; only the second stage is read by edge logic.
    nxt_st.irq_sync = {st_ff.irq_sync[0], ext_irq_pin};
    nxt_st.t0_sync = {st_ff.t0_sync[0], timer0_ext_clock_pin};
    nxt_st.irq_prev = st_ff.irq_sync[1];
    nxt_st.t0_prev = st_ff.t0_sync[1];

    // Core writes only the bank and reserved bits when flags are produced.
    if (status_wr) begin
      if (upd_znc || upd_z || upd_c) begin
        // Any flag-producing op blocks the data write to all three flags.
        st_w[ST_RSV7:ST_BANK] = status_wdata[ST_RSV7:ST_BANK]; // see R1
      end else begin
        st_w[ST_RSV7:ST_BANK] = status_wdata[ST_RSV7:ST_BANK]; // see R2
        st_w[ST_ZERO:ST_CARRY] = status_wdata[ST_ZERO:ST_CARRY];
      end
    end

    // Flag logic overrides the core data write to the flags; a bus write to status still wins.
    if (upd_znc || upd_z) begin
      st_w[ST_ZERO] = f_zero; // see R5
    end
    if (upd_znc) begin
      st_w[ST_NIBBLE] = f_nib; // see R6, R8
    end
    if (upd_znc || upd_c) begin
      st_w[ST_CARRY] = f_cy; // see R7, R9
    end

    // Bus write; the two read-only flags are never taken from data.
    if (wr_go) begin
      nxt_st.aw_held = 1'b0;
      nxt_st.w_held = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = RESP_OKAY;
      unique case (waddr)
        ADDR_STATUS: begin
          // Reset-cause flags are skipped, so software cannot forge them.
          if (wlane) begin
            st_w[ST_RSV7:ST_BANK] = wbyte[ST_RSV7:ST_BANK];
            st_w[ST_ZERO:ST_CARRY] = wbyte[ST_ZERO:ST_CARRY];
          end
        end
        ADDR_OPTION: begin
          if (wlane) begin
            nxt_st.option = wbyte;
          end
        end
        ADDR_EVENTS: begin
          sw_clear_ext = wlane && wbyte[EV_EXT_IRQ];
          sw_clear_t0 = wlane && wbyte[EV_T0_TICK];
        end
        ADDR_PULLUP: begin
          // Pull-up readback is read only; the write is accepted and dropped.
        end
        default: begin
          nxt_st.bresp = RESP_SLVERR;
        end
      endcase
    end else begin
      // Whichever half comes alone is held until the other one arrives.
      if (awvalid && awready) begin
        nxt_st.aw_held = 1'b1;
        nxt_st.aw_addr = awaddr;
      end
      if (wvalid && wready) begin
        nxt_st.w_held = 1'b1;
        nxt_st.w_data = wdata[7:0];
        nxt_st.w_strb0 = wstrb[0];
      end
    end
    if (st_ff.bvalid && bready) begin
      nxt_st.bvalid = 1'b0;
    end

    // Reset-cause flags; sleep wins over clear-watchdog for the sleep flag.
    if (watchdog_clear_op || sleep_op) begin
      st_w[ST_EXPIRY_N] = 1'b1; // see R3
    end else if (watchdog_timeout) begin
      st_w[ST_EXPIRY_N] = 1'b0; // see R3
    end
    if (sleep_op) begin
      st_w[ST_SLEEP_N] = 1'b0; // see R4
    end else if (watchdog_clear_op) begin
      st_w[ST_SLEEP_N] = 1'b1; // see R4
    end
    nxt_st.status = st_w;

    // Sticky event flags: a new event wins over a clear in the same cycle.
    if (sw_clear_ext) begin
      nxt_st.ext_flag = 1'b0;
    end
    if (irq_edge_hit) begin
      nxt_st.ext_flag = 1'b1; // see R19
    end

    // Timer tick flag, with the same priority as the pin flag.
    if (sw_clear_t0) begin
      nxt_st.t0_flag = 1'b0;
    end
    if (timer0_tick) begin
      nxt_st.t0_flag = 1'b1; // see R19
    end

    // Bus read returns the current register contents.
    if (rd_go) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = RESP_OKAY;
      unique case (araddr)
        ADDR_STATUS: begin
          nxt_st.rdata = {24'h00_0000, st_ff.status};
        end
        ADDR_OPTION: begin
          nxt_st.rdata = {24'h00_0000, st_ff.option};
        end
        ADDR_EVENTS: begin
          // Flags read as they stand; clearing takes a separate write of ones.
          nxt_st.rdata = {30'h0000_0000, st_ff.t0_flag, st_ff.ext_flag};
        end
        ADDR_PULLUP: begin
          // Shows the enables the pads really get, after the global disable.
          nxt_st.rdata = {26'h000_0000, pullup_en};
        end
        default: begin
          nxt_st.rdata = 32'h0000_0000;
          nxt_st.rresp = RESP_SLVERR;
        end
      endcase
    end else if (st_ff.rvalid && rready) begin
      nxt_st.rvalid = 1'b0;
    end
  end

  // State register; arithmetic flags start at zero as a defined value.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
      st_ff.status <= STATUS_RST; // see R21
      st_ff.option <= OPTION_RST; // see R21
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs.
  assign bvalid = st_ff.bvalid;
  assign bresp = st_ff.bresp;
  assign rvalid = st_ff.rvalid;
  assign rdata = st_ff.rdata;
  assign rresp = st_ff.rresp;

  // Register views and derived controls for the rest of the core.
  assign alu_result = res;
  assign bank_select = st_ff.status[ST_BANK]; // see R2
  assign pullup_en = st_ff.option[OP_PULLUP_DIS] ? 6'h00 : pullup_latch; // see R12
  assign ext_irq_flag = st_ff.ext_flag;
  assign core_status = st_ff.status;
  assign timer_option_ctrl = st_ff.option;
endmodule

/* File: verif/core_status_and_option_regs_sva.sv */
// Assertion checker for the status and option register block.
`timescale 1ns/1ps
module core_status_and_option_regs_sva
  import core_regs_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes.
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  // Core side.
  input wire alu_op_t alu_op,
  input wire logic [7:0] alu_a,
  input wire logic [7:0] alu_b,
  input wire logic [7:0] alu_result,
  input wire logic watchdog_clear_op,
  input wire logic sleep_op,
  input wire logic watchdog_timeout,
  // Register views.
  input wire logic [5:0] pullup_latch,
  input wire logic [5:0] pullup_en,
  input wire logic bank_select,
  input wire logic [7:0] core_status,
  input wire logic [7:0] timer_option_ctrl
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Reference arithmetic; cycles with a bus write are skipped because the bus may win there.
  logic [8:0] add9, sub9;
  logic [4:0] addn, subn;
  logic [7:0] exp_res;
  logic rot_out, bus_now;
  always_comb begin
    add9 = {1'b0, alu_a} + {1'b0, alu_b};
    sub9 = {1'b0, alu_a} + {1'b0, ~alu_b} + 9'h001;
    addn = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]};
    subn = {1'b0, alu_a[3:0]} + {1'b0, ~alu_b[3:0]} + 5'h01;
    exp_res = (alu_op == ALU_SUB) ? sub9[7:0] : (alu_op == ALU_ADD) ? add9[7:0] : alu_a & alu_b;
    rot_out = (alu_op == ALU_ROR) ? alu_a[0] : alu_a[7];
    bus_now = (awvalid && awready) || (wvalid && wready);
  end
  sequence s_op(alu_op_t o); alu_op == o && !bus_now; endsequence
  property p_bank; bank_select == core_status[ST_BANK]; endproperty
  a_bank: assert property (p_bank) else $error("bank select mismatch");
  property p_pull; pullup_en == (timer_option_ctrl[7] ? 6'h00 : pullup_latch); endproperty
  a_pull: assert property (p_pull) else $error("pull-up enable mismatch");
  property p_sleep; sleep_op |=> core_status[4:3] == 2'h2; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep flags wrong");
  property p_clr; watchdog_clear_op && !sleep_op |=> core_status[4:3] == 2'h3; endproperty
  a_clr: assert property (p_clr) else $error("clear flags wrong");
  property p_tmo; watchdog_timeout && !watchdog_clear_op && !sleep_op |=> !core_status[4];
  endproperty
  a_tmo: assert property (p_tmo) else $error("expiry flag not cleared");
  property p_hold; !(sleep_op || watchdog_clear_op || watchdog_timeout) |=>
    $stable(core_status[4:3]); endproperty
  a_hold: assert property (p_hold) else $error("read-only flags changed");
  property p_zero; s_op(ALU_ADD) or s_op(ALU_SUB) or s_op(ALU_LOGIC) |=>
    core_status[ST_ZERO] == ($past(exp_res) == 8'h00); endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  property p_add_c; s_op(ALU_ADD) |=> core_status[ST_CARRY] == $past(add9[8]); endproperty
  a_add_c: assert property (p_add_c) else $error("add carry wrong");
  property p_add_dc; s_op(ALU_ADD) |=> core_status[ST_NIBBLE] == $past(addn[4]); endproperty
  a_add_dc: assert property (p_add_dc) else $error("add nibble carry wrong");
  property p_sub; s_op(ALU_SUB) |=>
    core_status[1:0] == {$past(subn[4]), $past(sub9[8])}; endproperty
  a_sub: assert property (p_sub) else $error("subtract borrow flags wrong");
  property p_rot; s_op(ALU_ROR) or s_op(ALU_ROL) |=> core_status[ST_CARRY] == $past(rot_out);
  endproperty
  a_rot: assert property (p_rot) else $error("rotate carry wrong");
  property p_res; alu_op == ALU_ADD || alu_op == ALU_SUB |-> alu_result == exp_res; endproperty
  a_res: assert property (p_res) else $error("alu result wrong");
endmodule

bind core_status_and_option_regs core_status_and_option_regs_sva chk_u (.*);

/* File: verif/core_status_and_option_regs_tb_top.sv */
// Self-checking testbench for the status and option register block.
`timescale 1ns/1ps
module core_status_and_option_regs_tb_top import core_regs_pkg::*;;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, status_wr, watchdog_clear_op, sleep_op;
  logic watchdog_timeout, instr_tick, ext_irq_pin, timer0_ext_clock_pin;
  logic bank_select, timer0_tick, watchdog_tick, ext_irq_flag;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  alu_op_t alu_op;
  logic [7:0] alu_a, alu_b, status_wdata, alu_result, core_status, timer_option_ctrl, v, o, res;
  logic [5:0] pullup_latch, pullup_en;
  int error_cnt, checks, seed, t_cnt, w_cnt;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  // Each row: op, {status_wr, sleep, clear, timeout}, a, b, result, status after.
  logic [38:0] tbl [13] = '{{3'h1, 4'h0, 8'h0F, 8'h01, 8'h10, 8'h1A},
    {3'h1, 4'h0, 8'hFF, 8'h01, 8'h00, 8'h1F}, {3'h2, 4'h0, 8'h05, 8'h05, 8'h00, 8'h1F},
    {3'h2, 4'h0, 8'h03, 8'h05, 8'hFE, 8'h18}, {3'h3, 4'h0, 8'hF0, 8'h0F, 8'h00, 8'h1C},
    {3'h4, 4'h0, 8'h01, 8'h00, 8'h00, 8'h1D}, {3'h5, 4'h8, 8'h7F, 8'h00, 8'h00, 8'h3C},
    {3'h1, 4'h8, 8'h80, 8'h80, 8'h00, 8'h3D}, {3'h0, 4'h4, 8'h00, 8'h00, 8'h00, 8'h35},
    {3'h0, 4'h2, 8'h00, 8'h00, 8'h00, 8'h3D}, {3'h0, 4'h1, 8'h00, 8'h00, 8'h00, 8'h2D},
    {3'h0, 4'h5, 8'h00, 8'h00, 8'h00, 8'h35}, {3'h0, 4'h8, 8'h00, 8'h00, 8'h00, 8'h30}};

  core_status_and_option_regs dut_u (.*);

  always #4 aclk = ~aclk;

  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Address and data are offered together and each is dropped once it has been taken.
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r);
    logic ah, wh, ad = 1'b0, wd = 1'b0;
    bq.push_back(r);
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= {24'h00_0000, d};
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      ad |= ah;
      wd |= wh;
    end while (!(ad && wd));
    do @(negedge aclk); while (!bvalid);
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [33:0] e);
    rq.push_back(e);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  // One core cycle; the result is sampled mid-cycle, the status after the taking edge.
  task automatic core(input logic [2:0] op, input logic [3:0] ev, input logic [7:0] a, b);
    @(posedge aclk);
    alu_op <= alu_op_t'(op);
    alu_a <= a;
    alu_b <= b;
    {status_wr, sleep_op, watchdog_clear_op, watchdog_timeout} <= ev;
    @(negedge aclk);
    res = alu_result;
    @(posedge aclk);
    alu_op <= ALU_NONE;
    {status_wr, sleep_op, watchdog_clear_op, watchdog_timeout} <= 4'h0;
    @(negedge aclk);
  endtask

  // Whole prescaler periods are counted, so the count does not depend on the starting phase.
  task automatic ticks(input logic [7:0] op);
    int p;
    wr(ADDR_OPTION, op, RESP_OKAY);
    repeat (4) @(posedge aclk);
    t_cnt = 0;
    w_cnt = 0;
    for (p = 0; p < (op[OP_T0_SRC] ? 512 : 256); p++) begin
      @(posedge aclk);
      if (op[OP_T0_SRC]) timer0_ext_clock_pin <= ~timer0_ext_clock_pin;
      else instr_tick <= 1'b1;
      @(posedge aclk);
      instr_tick <= 1'b0;
      repeat (3) @(posedge aclk);
    end
    repeat (6) @(posedge aclk);
    chk("timer ticks", op[3] ? 256 : 256 >> (int'(op[2:0]) + 1), t_cnt);
    if (op[3]) chk("watchdog ticks", 256 >> op[2:0], w_cnt);
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Results are matched against the oldest note in the moment before they are taken.
  always @(negedge aclk) begin
    t_cnt += int'(timer0_tick);
    w_cnt += int'(watchdog_tick);
    if (rvalid && rready && rq.size() > 0) chk("rdata", rq.pop_front(), {rresp, rdata});
    if (bvalid && bready && bq.size() > 0) chk("bresp", {32'h0, bq.pop_front()}, {32'h0, bresp});
  end

  initial begin
    repeat (40000) @(posedge aclk);
    error_cnt++;
    end_of_test();
  end

  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, status_wr} = 8'h00;
    {sleep_op, watchdog_clear_op, watchdog_timeout, instr_tick} = 4'h0;
    {ext_irq_pin, timer0_ext_clock_pin, alu_a, alu_b, pullup_latch} = 24'h00_0000;
    {awaddr, araddr, wstrb, wdata} = {8'h00, 4'hF, 32'h0};
    alu_op = ALU_NONE;
    status_wdata = 8'h20;
    seed = 32'h905f_b162;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_STATUS, {2'h0, 32'h18});
    rd(ADDR_OPTION, {2'h0, 32'hFF});
    rd(4'h2, {RESP_SLVERR, 32'h0});
    wr(4'h2, 8'hFF, RESP_SLVERR);
    wr(ADDR_STATUS, 8'h27, RESP_OKAY);
    rd(ADDR_STATUS, {2'h0, 32'h3F});
    chk("bank_select", 34'h1, {33'h0, bank_select});
    wr(ADDR_STATUS, 8'h00, RESP_OKAY);
    rd(ADDR_STATUS, {2'h0, 32'h18});
    foreach (tbl[k]) begin
      core(tbl[k][38:36], tbl[k][35:32], tbl[k][31:24], tbl[k][23:16]);
      if (tbl[k][38:36] inside {3'h1, 3'h2, 3'h3}) chk("alu", 34'(tbl[k][15:8]), 34'(res));
      chk("core_status", 34'(tbl[k][7:0]), 34'(core_status));
    end
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      o = {i[0], v[6:0]};
      pullup_latch <= v[5:0];
      wr(ADDR_OPTION, o, RESP_OKAY);
      rd(ADDR_OPTION, {26'h0, o});
      chk("timer_option_ctrl", 34'(o), 34'(timer_option_ctrl));
      chk("pullup_en", 34'(o[7] ? 6'h00 : v[5:0]), 34'(pullup_en));
      wr(ADDR_PULLUP, 8'hFF, RESP_OKAY);
      rd(ADDR_PULLUP, 34'(o[7] ? 6'h00 : v[5:0]));
    end
    // The wrong edge comes last, after a clear, so a stray set cannot hide.
    for (int i = 1; i >= 0; i--) begin
      wr(ADDR_OPTION, {1'b1, i[0], 6'h08}, RESP_OKAY);
      ext_irq_pin <= ~i[0];
      repeat (6) @(posedge aclk);
      wr(ADDR_EVENTS, 8'h03, RESP_OKAY);
      ext_irq_pin <= i[0];
      repeat (6) @(posedge aclk);
      rd(ADDR_EVENTS, 34'h1);
      chk("ext_irq_flag", 34'h1, 34'(ext_irq_flag));
      wr(ADDR_EVENTS, 8'h03, RESP_OKAY);
      ext_irq_pin <= ~i[0];
      repeat (6) @(posedge aclk);
      rd(ADDR_EVENTS, 34'h0);
      chk("ext_irq_flag", 34'h0, 34'(ext_irq_flag));
    end
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      ticks({2'h0, i[0], v[4], i[1], v[2:0]});
    end
    rd(ADDR_EVENTS, 34'h2);
    end_of_test();
  end
endmodule
